//--- tb/bbl_exec_properties.sv
// Checker on the ports of the execution unit.
// Assumes the fastest CPU clock for exact times.
`timescale 1ns/1ns
`default_nettype none
module bbl_exec_properties (
   // Inputs watched
   input  wire logic                 core_clk_in,
   input  wire logic                 srst_in,
   input  wire logic [2:0]           processor_clock_control_in,
   input  wire logic                 start_in,
   input  wire bbl_pkg::bbl_req_type req_in,
   // Outputs watched
   input  wire logic                 ready_out,
   input  wire logic                 busy_out,
   input  wire logic                 done_out,
   input  wire bbl_pkg::bbl_res_type res_out,
   input  wire logic                 bad_form_out,
   input  wire logic                 master_interrupt_enable_flag_out,
   input  wire logic [1:0]           bank_select_bits_out,
   input  wire logic                 halt_out
);
   bbl_pkg::bbl_req_type req_ff;
   logic                 go;
   // Request behind the next done
   assign go = start_in && ready_out;
   always_ff @(posedge core_clk_in) if (go) req_ff <= req_in;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   a_done_pulse: assert property (done_out |=> !done_out)
      else $error("done too long");
   a_accept_busy: assert property (go |=> busy_out && !ready_out)
      else $error("not accepted");
   a_nop_clocks: assert property (go && req_in.op == bbl_pkg::OP_NOP
      && processor_clock_control_in == 3'h0 |=> !done_out [*2] ##1 done_out)
      else $error("no-op time wrong");
   a_ei_clocks: assert property (go && req_in.op == bbl_pkg::OP_EI
      && processor_clock_control_in == 3'h0 |=> !done_out [*6] ##1 done_out)
      else $error("enable time");
   a_ie_set: assert property (done_out && req_ff.op == bbl_pkg::OP_EI
      |-> master_interrupt_enable_flag_out) else $error("enable not set");
   a_ie_clear: assert property (done_out && req_ff.op == bbl_pkg::OP_DI
      |-> !master_interrupt_enable_flag_out) else $error("enable not cleared");
   a_bank_write: assert property (done_out && req_ff.op == bbl_pkg::OP_SEL
      |-> bank_select_bits_out == req_ff.register_bank_number)
      else $error("bank bits wrong");
   a_set_taken: assert property (done_out && !bad_form_out
      && req_ff.op == bbl_pkg::OP_BIT_SET
      |-> res_out.taken == req_ff.opnd[req_ff.bit_idx]) else $error("set test");
   a_clr_taken: assert property (done_out && !bad_form_out
      && req_ff.op == bbl_pkg::OP_BIT_CLR
      |-> res_out.taken != req_ff.opnd[req_ff.bit_idx]) else $error("clr test");
   a_loop_dec: assert property (done_out && req_ff.op == bbl_pkg::OP_DEC_BNZ
      && !bad_form_out |-> res_out.wb_data == req_ff.opnd - 8'h01
      && res_out.taken == (res_out.wb_data != 8'h00)) else $error("loop step");
   a_flags_kept: assert property (done_out
      && req_ff.op != bbl_pkg::OP_SET_CLR |-> !res_out.flag_en)
      else $error("flags touched");
   a_halt_enter: assert property (done_out && req_ff.op == bbl_pkg::OP_HALT
      |-> halt_out) else $error("no halt");
endmodule : bbl_exec_properties
bind bbl_exec bbl_exec_properties u_props (.*);
`default_nettype wire

//--- tb/bbl_mem_model.sv
// Data memory behind the execution unit.
// Assumes the bench moves operands and results.
`timescale 1ns/1ns
`default_nettype none
module bbl_mem_model #(
   parameter logic [7:0] HS_BASE = 8'h80
) (
   // Clock and access
   input  wire logic       core_clk_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   // Read side
   output logic [7:0]      rdata_out,
   output logic            ext_out
);
   logic [7:0] mem_ff [256];
   // below fast RAM base is another area
   assign ext_out   = (addr_in < HS_BASE);
   assign rdata_out = mem_ff[addr_in];
   always_ff @(posedge core_clk_in) begin
      if (wr_in) mem_ff[addr_in] <= wdata_in;
   end
endmodule : bbl_mem_model
`default_nettype wire

//--- tb/testbench.sv
// Directed bench for the execution unit and its data memory.
// Assumes 100 MHz clock, sync active high reset.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic core_clk_in = 1'b0, srst_in = 1'b1, start_in = 1'b0, wake = 1'b0;
   logic [2:0] processor_clock_control = 3'h0;
   bbl_pkg::bbl_req_type req = '0;
   bbl_pkg::bbl_chk_type chk = '0;
   bbl_pkg::bbl_res_type res;
   logic ready, busy, done, bad, ie, halt, stop, legal, ext, wr = 1'b0;
   logic [1:0] bank;
   logic [7:0] addr = 8'h40, wdata = 8'h00, rdata;
   int n_fail = 0, total_checks = 0, cyc;
   bbl_exec uut (.core_clk_in, .srst_in, .processor_clock_control_in(processor_clock_control),
      .start_in, .req_in(req), .ready_out(ready), .busy_out(busy),
      .done_out(done), .res_out(res), .bad_form_out(bad),
      .master_interrupt_enable_flag_out(ie), .bank_select_bits_out(bank),
      .halt_out(halt), .stop_out(stop), .wake_in(wake), .chk_in(chk),
      .chk_legal_out(legal));
   bbl_mem_model mem (.core_clk_in, .wr_in(wr), .addr_in(addr),
      .wdata_in(wdata), .rdata_out(rdata), .ext_out(ext));
   initial forever #5 core_clk_in = ~core_clk_in;
   task automatic check(input string what, input logic [15:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h got %h", what, exp, got);
      end
   endtask : check
   task automatic results;
      if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   // One instruction, up to the done cycle
   task automatic run(input bbl_pkg::bbl_op_type op,
         input bbl_pkg::bbl_space_type sp, input logic [2:0] b,
         input logic [7:0] v, input logic x, tk, input logic [2:0] len,
         input logic [3:0] n);
      @(posedge core_clk_in);
      req <= '{op, sp, b, 8'hF0, 16'h1000, v, x, 2'h2};
      start_in <= 1'b1;
      @(posedge core_clk_in);
      start_in <= 1'b0;
      cyc = 0;
      do begin
         @(negedge core_clk_in);
         cyc++;
      end while (done !== 1'b1 && cyc < 400);
      if (cyc >= 400) begin
         n_fail++;
         results();
      end
      // Length zero: refused form
      if (len != 3'h0) begin
         check("taken", {15'h0, tk}, {15'h0, res.taken});
         check("pc_next", 16'h1000 + 16'(len) + (tk ? 16'hFFF0 : 16'h0),
            res.pc_next);
      end
      if (processor_clock_control == 3'h0) check("clocks", 16'(n) + 16'h1, 16'(cyc));
   endtask : run
   task automatic poke(input logic [7:0] v);
      @(posedge core_clk_in);
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk_in);
      wr <= 1'b0;
      @(negedge core_clk_in);
   endtask : poke
   task automatic ctl(input bbl_pkg::bbl_op_type op, input logic [3:0] n);
      run(op, bbl_pkg::SP_SADDR, 0, 8'h00, 0, 0,
         op == bbl_pkg::OP_NOP ? 3'h1 : 3'h2, n);
   endtask : ctl
   task automatic legal_is(input bbl_pkg::bbl_chk_type c, input logic e);
      @(posedge core_clk_in);
      chk <= c;
      @(negedge core_clk_in);
      check("legal", {15'h0, e}, {15'h0, legal});
   endtask : legal_is
   task automatic wake_up;
      @(posedge core_clk_in);
      wake <= 1'b1;
      @(posedge core_clk_in);
      wake <= 1'b0;
      @(negedge core_clk_in);
      check("awake", 16'h0004, {13'h0, ready, halt, stop});
   endtask : wake_up
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk_in);
      srst_in <= 1'b0;
      @(negedge core_clk_in);
      check("reset", 16'h0080, {8'h0, ready, ie, bank, halt, stop, busy, done});
      run(bbl_pkg::OP_BIT_SET, bbl_pkg::SP_SADDR, 3, 8'h08, 0, 1, 3, 8);
      run(bbl_pkg::OP_BIT_SET, bbl_pkg::SP_SFR, 7, 8'h7F, 1, 0, 4, 11);
      run(bbl_pkg::OP_BIT_SET, bbl_pkg::SP_HL, 0, 8'h01, 1, 1, 3, 11);
      run(bbl_pkg::OP_BIT_CLR, bbl_pkg::SP_SADDR, 0, 8'h00, 0, 1, 4, 10);
      run(bbl_pkg::OP_BIT_CLR, bbl_pkg::SP_PSW, 6, 8'h40, 0, 0, 4, 11);
      run(bbl_pkg::OP_BIT_CLR, bbl_pkg::SP_ACC, 0, 8'hFE, 0, 1, 3, 8);
      run(bbl_pkg::OP_SET_CLR, bbl_pkg::SP_PSW, 6, 8'h51, 0, 1, 4, 12);
      check("psw clear", 16'h111B, {3'h0, res[12:0]});
      run(bbl_pkg::OP_SET_CLR, bbl_pkg::SP_ACC, 0, 8'h00, 0, 0, 3, 8);
      check("no write", 16'h0000, {15'h0, res.wb_en});
      run(bbl_pkg::OP_DEC_BNZ, bbl_pkg::SP_REG_C, 0, 8'h01, 0, 0, 2, 6);
      poke(8'h05);
      run(bbl_pkg::OP_DEC_BNZ, bbl_pkg::SP_SADDR, 0, rdata, ext, 1, 3, 10);
      if (res.wb_en === 1'b1) poke(res.wb_data);
      check("loop byte", 16'h0004, {8'h0, rdata});
      ctl(bbl_pkg::OP_SEL, 4);
      ctl(bbl_pkg::OP_EI, 6);
      check("ie on", 16'h0006, {13'h0, ie, bank});
      ctl(bbl_pkg::OP_DI, 6);
      check("ie off", 16'h0000, {15'h0, ie});
      ctl(bbl_pkg::OP_NOP, 2);
      ctl(bbl_pkg::OP_HALT, 6);
      wake_up();
      ctl(bbl_pkg::OP_STOP, 6);
      wake_up();
      run(bbl_pkg::OP_BIT_SET, bbl_pkg::SP_REG_B, 0, 8'h00, 0, 0, 0, 2);
      check("bad form", 16'h0001, {15'h0, bad});
      @(posedge core_clk_in) processor_clock_control <= 3'h1;
      ctl(bbl_pkg::OP_NOP, 2);
      check("slow clocks", 16'h0001, {15'h0, cyc >= 4 && cyc <= 7});
      legal_is('{bbl_pkg::CLS_ARITH, bbl_pkg::OPND_ACC, bbl_pkg::OPND_IMM}, 1);
      legal_is('{bbl_pkg::CLS_ARITH, bbl_pkg::OPND_ACC, bbl_pkg::OPND_SFR}, 0);
      legal_is('{bbl_pkg::CLS_XCH, bbl_pkg::OPND_ACC, bbl_pkg::OPND_PSW}, 0);
      legal_is('{bbl_pkg::CLS_ROT, bbl_pkg::OPND_ACC, bbl_pkg::OPND_NONE}, 1);
      results();
   end
endmodule : testbench
`default_nettype wire

//--- verilog/bbl_defines.svh
// Constants for the bit-branch, loop and CPU control execution unit.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef BBL_DEFINES_SVH
`define BBL_DEFINES_SVH

// Instruction lengths in bytes
`define BBL_LEN_ONE   3'h1
`define BBL_LEN_TWO   3'h2
`define BBL_LEN_THREE 3'h3
`define BBL_LEN_FOUR  3'h4

// Instruction clocks, branch if bit set
`define BBL_CK_BT_SADDR_RAM 4'h8
`define BBL_CK_BT_SADDR_EXT 4'h9
`define BBL_CK_BT_SFR       4'hB
`define BBL_CK_BT_ACC       4'h8
`define BBL_CK_BT_PSW       4'h9
`define BBL_CK_BT_HL_RAM    4'hA
`define BBL_CK_BT_HL_EXT    4'hB

// Instruction clocks, branch if bit clear
`define BBL_CK_BF_SADDR_RAM 4'hA
`define BBL_CK_BF_SADDR_EXT 4'hB
`define BBL_CK_BF_SFR       4'hB
`define BBL_CK_BF_ACC       4'h8
`define BBL_CK_BF_PSW       4'hB
`define BBL_CK_BF_HL_RAM    4'hA
`define BBL_CK_BF_HL_EXT    4'hB

// Instruction clocks, branch if set then clear
`define BBL_CK_BC_MEM_RAM   4'hA
`define BBL_CK_BC_MEM_EXT   4'hC
`define BBL_CK_BC_ACC       4'h8

// Instruction clocks, loop and CPU control
`define BBL_CK_DB_REG       4'h6
`define BBL_CK_DB_SADDR_RAM 4'h8
`define BBL_CK_DB_SADDR_EXT 4'hA
`define BBL_CK_SEL          4'h4
`define BBL_CK_NOP          4'h2
`define BBL_CK_CTRL         4'h6

// Flag positions inside the program status word
`define BBL_PSW_Z  3'h6
`define BBL_PSW_AC 3'h4
`define BBL_PSW_CY 3'h0

`endif

//--- verilog/bbl_exec.sv
// Execution unit for bit-test branches, the decrement loop, CPU
// control and an 8-bit operand legality check.
// Assumes operand fetch and write-back outside; results come at done.
`timescale 1ns/1ns
`default_nettype none
`include "bbl_defines.svh"

// How it works
// [RULE1] Counts run on CPU clock enable ticks
// [RULE2] Other data areas use the second column
// [RULE3] Set-bit branch: pc plus length plus displacement
// [RULE4] Set-bit branch takes eight to eleven clocks
// [RULE5] Clear-bit branch taken only when bit zero
// [RULE6] Clear-bit branch takes eight to eleven clocks
// [RULE7] Set-then-clear branches and clears set bit
// [RULE8] Status word clear updates flags; others untouched
// [RULE9] Register loop: decrement, branch if nonzero
// [RULE10] Memory loop: decrement, write back, branch
// [RULE11] Enable op sets master interrupt enable
// [RULE12] Disable op clears master interrupt enable
// [RULE13] Accumulator-first operand legality per operation class
// [RULE14] Bank select, no-op, halt and stop
// [RULE15] High-speed RAM or no data uses first column
module bbl_exec (
   // Clock and reset
   input  wire logic                 core_clk_in,
   input  wire logic                 srst_in,
   // CPU clock select (divide by 1, 2, 4, 8, 16)
   input  wire logic [2:0]           processor_clock_control_in,
   // Instruction request
   input  wire logic                 start_in,
   input  wire bbl_pkg::bbl_req_type req_in,
   output logic                      ready_out,
   output logic                      busy_out,
   // Completion
   output logic                      done_out,
   output bbl_pkg::bbl_res_type      res_out,
   output logic                      bad_form_out,
   // CPU control state
   output logic                      master_interrupt_enable_flag_out,
   output logic [1:0]                bank_select_bits_out,
   output logic                      halt_out,
   output logic                      stop_out,
   input  wire logic                 wake_in,
   // Operand legality query
   input  wire bbl_pkg::bbl_chk_type chk_in,
   output logic                      chk_legal_out
);

   bbl_pkg::bbl_state_type state_ff;
   bbl_pkg::bbl_state_type nxt_state;
   bbl_pkg::bbl_req_type   req_ff;
   bbl_pkg::bbl_req_type   nxt_req;
   bbl_pkg::bbl_res_type   res_ff;
   bbl_pkg::bbl_res_type   nxt_res;
   logic [3:0]             div_cnt_ff;
   logic [3:0]             nxt_div_cnt;
   logic [3:0]             div_mask;
   logic                   cpu_tick;
   logic [3:0]             clk_cnt_ff;
   logic [3:0]             nxt_clk_cnt;
   logic                   bad_ff;
   logic                   nxt_bad;
   logic                   ie_ff;
   logic                   nxt_ie;
   logic [1:0]             bank_ff;
   logic [1:0]             nxt_bank;
   logic                   halt_ff;
   logic                   nxt_halt;
   logic                   stop_ff;
   logic                   nxt_stop;
   logic [2:0]             len;
   logic [3:0]             clocks;
   logic                   form_ok;
   logic                   finish;
   logic                   tested;
   logic [7:0]             cleared;
   logic [7:0]             decd;
   logic                   taken;
   logic [15:0]            seq_pc;

   // Length and clock count of the latched instruction
   bbl_timing u_timing (
      .op_in       (req_ff.op),
      .space_in    (req_ff.space),
      .ext_area_in (req_ff.ext_area),
      .len_out     (len),
      .clocks_out  (clocks),
      .form_ok_out (form_ok)
   );

   // CPU clock enable divider; the counter runs free and the mask is decoded
   // combinationally, so a change of divisor takes effect in the same cycle
   always_comb begin
      case (processor_clock_control_in)
         3'h0:    div_mask = 4'h0;
         3'h1:    div_mask = 4'h1;
         3'h2:    div_mask = 4'h3;
         3'h3:    div_mask = 4'h7;
         default: div_mask = 4'hF;
      endcase
      nxt_div_cnt = div_cnt_ff + 4'h1;
      cpu_tick    = (div_cnt_ff & div_mask) == div_mask;
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         div_cnt_ff <= 4'h0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   // Datapath of the bit test and loop decrement
   always_comb begin
      tested  = req_ff.opnd[req_ff.bit_idx];
      cleared = req_ff.opnd & ~(8'h01 << req_ff.bit_idx);
      decd    = req_ff.opnd - 8'h01;
      seq_pc  = req_ff.pc + {13'h0000, len};
      case (req_ff.op)
         // [RULE3] taken on bit one
         bbl_pkg::OP_BIT_SET: taken = tested;
         // [RULE5] taken on bit zero
         bbl_pkg::OP_BIT_CLR: taken = ~tested;
         bbl_pkg::OP_SET_CLR: taken = tested;
         // [RULE9] branch on nonzero result
         bbl_pkg::OP_DEC_BNZ: taken = decd != 8'h00;
         default:             taken = 1'b0;
      endcase
      finish = (state_ff == bbl_pkg::ST_COUNT) && cpu_tick &&
               (clk_cnt_ff + 4'h1 == clocks);
   end

   // Result word, captured once when the count completes
   always_comb begin
      nxt_res = res_ff;
      if (finish) begin
         nxt_res.taken   = taken;
         nxt_res.pc_next = taken ?
            seq_pc + {{8{req_ff.jump_displacement[7]}},
                      req_ff.jump_displacement} : seq_pc;
         nxt_res.wb_en   = 1'b0;
         nxt_res.wb_data = req_ff.opnd;
         nxt_res.flag_en = 1'b0;
         // [RULE7] clear the bit only when taken
         if (req_ff.op == bbl_pkg::OP_SET_CLR && tested) begin
            nxt_res.wb_en   = 1'b1;
            nxt_res.wb_data = cleared;
            // [RULE8] flags follow the cleared word
            nxt_res.flag_en = req_ff.space == bbl_pkg::SP_PSW;
         end
         // [RULE10] decremented byte written back
         if (req_ff.op == bbl_pkg::OP_DEC_BNZ) begin
            nxt_res.wb_en   = 1'b1;
            nxt_res.wb_data = decd;
         end
         nxt_res.zero                 = cleared[`BBL_PSW_Z];
         nxt_res.auxiliary_carry_flag = cleared[`BBL_PSW_AC];
         nxt_res.carry_flag           = cleared[`BBL_PSW_CY];
      end
   end

   // Controller: accept, count CPU clocks, report
   always_comb begin
      nxt_state   = state_ff;
      nxt_req     = req_ff;
      nxt_clk_cnt = clk_cnt_ff;
      nxt_bad     = bad_ff;
      case (state_ff)
         bbl_pkg::ST_IDLE: begin
            if (start_in && ready_out) begin
               nxt_req     = req_in;
               nxt_clk_cnt = 4'h0;
               nxt_state   = bbl_pkg::ST_COUNT;
            end
         end
         bbl_pkg::ST_COUNT: begin
            // [RULE1] one count per CPU clock
            if (cpu_tick) begin
               nxt_clk_cnt = clk_cnt_ff + 4'h1;
            end
            if (finish) begin
               nxt_bad   = ~form_ok;
               nxt_state = bbl_pkg::ST_DONE;
            end
         end
         bbl_pkg::ST_DONE: nxt_state = bbl_pkg::ST_IDLE;
         default:          nxt_state = bbl_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         state_ff   <= bbl_pkg::ST_IDLE;
         req_ff     <= '0;
         clk_cnt_ff <= 4'h0;
         bad_ff     <= 1'b0;
         res_ff     <= '0;
      end else begin
         state_ff   <= nxt_state;
         req_ff     <= nxt_req;
         clk_cnt_ff <= nxt_clk_cnt;
         bad_ff     <= nxt_bad;
         res_ff     <= nxt_res;
      end
   end

   // CPU control state changes at completion; a bad form does nothing.
   // Wake releases standby, but a standby entry in the same cycle wins.
   always_comb begin
      nxt_ie   = ie_ff;
      nxt_bank = bank_ff;
      nxt_halt = halt_ff & ~wake_in;
      nxt_stop = stop_ff & ~wake_in;
      if (finish && form_ok) begin
         case (req_ff.op)
            // [RULE11] enable interrupts
            bbl_pkg::OP_EI:   nxt_ie = 1'b1;
            // [RULE12] disable interrupts
            bbl_pkg::OP_DI:   nxt_ie = 1'b0;
            // [RULE14] bank and standby
            bbl_pkg::OP_SEL:  nxt_bank = req_ff.register_bank_number;
            bbl_pkg::OP_HALT: nxt_halt = 1'b1;
            bbl_pkg::OP_STOP: nxt_stop = 1'b1;
            default:          ;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         ie_ff   <= 1'b0;
         bank_ff <= 2'h0;
         halt_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else begin
         ie_ff   <= nxt_ie;
         bank_ff <= nxt_bank;
         halt_ff <= nxt_halt;
         stop_ff <= nxt_stop;
      end
   end

   // 8-bit operand legality; the accumulator-first row is the broad one
   always_comb begin
      chk_legal_out = 1'b0;
      case (chk_in.first)
         // [RULE13] accumulator first row
         bbl_pkg::OPND_ACC: begin
            case (chk_in.cls)
               bbl_pkg::CLS_ARITH: chk_legal_out =
                  chk_in.second inside {bbl_pkg::OPND_IMM,
                     bbl_pkg::OPND_REG, bbl_pkg::OPND_SADDR,
                     bbl_pkg::OPND_ABS, bbl_pkg::OPND_HL_IND,
                     bbl_pkg::OPND_HL_IDX};
               bbl_pkg::CLS_MOV,
               bbl_pkg::CLS_XCH: chk_legal_out =
                  chk_in.second inside {bbl_pkg::OPND_REG,
                     bbl_pkg::OPND_SFR, bbl_pkg::OPND_SADDR,
                     bbl_pkg::OPND_ABS, bbl_pkg::OPND_DE_IND,
                     bbl_pkg::OPND_HL_IND, bbl_pkg::OPND_HL_IDX} ||
                  (chk_in.cls == bbl_pkg::CLS_MOV &&
                   chk_in.second == bbl_pkg::OPND_PSW);
               bbl_pkg::CLS_ROT: chk_legal_out =
                  chk_in.second == bbl_pkg::OPND_NONE;
               default: chk_legal_out = 1'b0;
            endcase
         end
         bbl_pkg::OPND_REG: chk_legal_out =
            (chk_in.cls == bbl_pkg::CLS_MOV &&
             chk_in.second inside {bbl_pkg::OPND_IMM,
                                   bbl_pkg::OPND_ACC}) ||
            (chk_in.cls == bbl_pkg::CLS_ARITH &&
             chk_in.second == bbl_pkg::OPND_ACC) ||
            (chk_in.cls == bbl_pkg::CLS_INCDEC &&
             chk_in.second == bbl_pkg::OPND_NONE);
         bbl_pkg::OPND_SADDR: chk_legal_out =
            (chk_in.cls == bbl_pkg::CLS_MOV &&
             chk_in.second inside {bbl_pkg::OPND_IMM,
                                   bbl_pkg::OPND_ACC}) ||
            (chk_in.cls == bbl_pkg::CLS_ARITH &&
             chk_in.second == bbl_pkg::OPND_IMM) ||
            (chk_in.cls == bbl_pkg::CLS_INCDEC &&
             chk_in.second == bbl_pkg::OPND_NONE);
         bbl_pkg::OPND_SFR,
         bbl_pkg::OPND_PSW: chk_legal_out =
            chk_in.cls == bbl_pkg::CLS_MOV &&
            chk_in.second inside {bbl_pkg::OPND_IMM, bbl_pkg::OPND_ACC};
         bbl_pkg::OPND_ABS,
         bbl_pkg::OPND_DE_IND,
         bbl_pkg::OPND_HL_IDX: chk_legal_out =
            chk_in.cls == bbl_pkg::CLS_MOV &&
            chk_in.second == bbl_pkg::OPND_ACC;
         bbl_pkg::OPND_HL_IND: chk_legal_out =
            (chk_in.cls == bbl_pkg::CLS_MOV &&
             chk_in.second == bbl_pkg::OPND_ACC) ||
            (chk_in.cls == bbl_pkg::CLS_ROT &&
             chk_in.second == bbl_pkg::OPND_NONE);
         default: chk_legal_out = 1'b0;
      endcase
   end

   // Outputs; standby refuses new work until wake
   assign ready_out    = (state_ff == bbl_pkg::ST_IDLE) &&
                         ~halt_ff && ~stop_ff;
   assign busy_out     = state_ff != bbl_pkg::ST_IDLE;
   assign done_out     = state_ff == bbl_pkg::ST_DONE;
   assign res_out      = res_ff;
   assign bad_form_out = bad_ff & done_out;
   assign master_interrupt_enable_flag_out = ie_ff;
   assign bank_select_bits_out = bank_ff;
   assign halt_out     = halt_ff;
   assign stop_out     = stop_ff;

endmodule : bbl_exec
`default_nettype wire

//--- verilog/bbl_pkg.sv
// Types shared by the execution unit and its timing table.
// Assumes bbl_defines.svh supplies the lengths, clock counts and flag positions; state codes are set here.
package bbl_pkg;

   // Instruction being executed
   typedef enum logic [3:0] {
      OP_BIT_SET, OP_BIT_CLR, OP_SET_CLR, OP_DEC_BNZ, OP_SEL,
      OP_NOP, OP_EI, OP_DI, OP_HALT, OP_STOP
   } bbl_op_type;

   // Where the tested bit or loop count lives
   typedef enum logic [2:0] {
      SP_SADDR, SP_SFR, SP_ACC, SP_PSW, SP_HL, SP_REG_B, SP_REG_C
   } bbl_space_type;

   // Operand kinds for 8-bit operation legality
   typedef enum logic [3:0] {
      OPND_IMM, OPND_ACC, OPND_REG, OPND_SFR, OPND_SADDR, OPND_ABS,
      OPND_PSW, OPND_DE_IND, OPND_HL_IND, OPND_HL_IDX, OPND_NONE
   } bbl_opnd_type;

   typedef enum logic [2:0] {
      CLS_MOV, CLS_XCH, CLS_ARITH, CLS_ROT, CLS_INCDEC
   } bbl_class_type;

   // Controller state, one-hot
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_COUNT = 3'b010,
      ST_DONE  = 3'b100
   } bbl_state_type;

   typedef struct packed {
      bbl_op_type    op;
      bbl_space_type space;
      logic [2:0]    bit_idx;
      logic [7:0]    jump_displacement;
      logic [15:0]   pc;
      logic [7:0]    opnd;
      logic          ext_area;
      logic [1:0]    register_bank_number;
   } bbl_req_type;

   typedef struct packed {
      logic [15:0] pc_next;
      logic        taken;
      logic        wb_en;
      logic [7:0]  wb_data;
      logic        flag_en;
      logic        zero;
      logic        auxiliary_carry_flag;
      logic        carry_flag;
   } bbl_res_type;

   typedef struct packed {
      bbl_class_type cls;
      bbl_opnd_type  first;
      bbl_opnd_type  second;
   } bbl_chk_type;

endpackage : bbl_pkg

//--- verilog/bbl_timing.sv
// Length and clock-count table for each instruction form.
// Assumes ext_area_in is high when a data area other than the internal
// high-speed RAM is touched; forms with one column ignore it.
`timescale 1ns/1ns
`default_nettype none
`include "bbl_defines.svh"

module bbl_timing (
   // Instruction form
   input  wire bbl_pkg::bbl_op_type    op_in,
   input  wire bbl_pkg::bbl_space_type space_in,
   input  wire logic                   ext_area_in,
   // Table answer
   output logic [2:0]                  len_out,
   output logic [3:0]                  clocks_out,
   output logic                        form_ok_out
);

   // Table lookup; unknown forms report as bad and cost a no-op, except set-then-clear, which keeps its memory count
   always_comb begin
      len_out     = `BBL_LEN_ONE;
      clocks_out  = `BBL_CK_NOP;
      form_ok_out = 1'b1;
      case (op_in)
         // [RULE4] set-bit timing
         bbl_pkg::OP_BIT_SET: begin
            len_out = `BBL_LEN_THREE;
            case (space_in)
               // [RULE2] second column select
               bbl_pkg::SP_SADDR: clocks_out = ext_area_in ?
                  `BBL_CK_BT_SADDR_EXT : `BBL_CK_BT_SADDR_RAM;
               bbl_pkg::SP_SFR: begin
                  len_out    = `BBL_LEN_FOUR;
                  clocks_out = `BBL_CK_BT_SFR;
               end
               bbl_pkg::SP_ACC: clocks_out = `BBL_CK_BT_ACC;
               bbl_pkg::SP_PSW: clocks_out = `BBL_CK_BT_PSW;
               // [RULE15] first column select
               bbl_pkg::SP_HL: clocks_out = ext_area_in ?
                  `BBL_CK_BT_HL_EXT : `BBL_CK_BT_HL_RAM;
               default: form_ok_out = 1'b0;
            endcase
         end
         // [RULE6] clear-bit timing
         bbl_pkg::OP_BIT_CLR: begin
            len_out = `BBL_LEN_FOUR;
            case (space_in)
               bbl_pkg::SP_SADDR: clocks_out = ext_area_in ?
                  `BBL_CK_BF_SADDR_EXT : `BBL_CK_BF_SADDR_RAM;
               bbl_pkg::SP_SFR: clocks_out = `BBL_CK_BF_SFR;
               bbl_pkg::SP_ACC: begin
                  len_out    = `BBL_LEN_THREE;
                  clocks_out = `BBL_CK_BF_ACC;
               end
               bbl_pkg::SP_PSW: clocks_out = `BBL_CK_BF_PSW;
               bbl_pkg::SP_HL: begin
                  len_out    = `BBL_LEN_THREE;
                  clocks_out = ext_area_in ?
                     `BBL_CK_BF_HL_EXT : `BBL_CK_BF_HL_RAM;
               end
               default: form_ok_out = 1'b0;
            endcase
         end
         // [RULE7] set-then-clear timing
         bbl_pkg::OP_SET_CLR: begin
            len_out    = `BBL_LEN_FOUR;
            clocks_out = ext_area_in ?
               `BBL_CK_BC_MEM_EXT : `BBL_CK_BC_MEM_RAM;
            case (space_in)
               bbl_pkg::SP_SADDR: ;
               bbl_pkg::SP_SFR,
               bbl_pkg::SP_PSW: clocks_out = `BBL_CK_BC_MEM_EXT;
               bbl_pkg::SP_ACC: begin
                  len_out    = `BBL_LEN_THREE;
                  clocks_out = `BBL_CK_BC_ACC;
               end
               bbl_pkg::SP_HL: len_out = `BBL_LEN_THREE;
               default: form_ok_out = 1'b0;
            endcase
         end
         bbl_pkg::OP_DEC_BNZ: begin
            case (space_in)
               // [RULE9] register loop timing
               bbl_pkg::SP_REG_B,
               bbl_pkg::SP_REG_C: begin
                  len_out    = `BBL_LEN_TWO;
                  clocks_out = `BBL_CK_DB_REG;
               end
               // [RULE10] memory loop timing
               bbl_pkg::SP_SADDR: begin
                  len_out    = `BBL_LEN_THREE;
                  clocks_out = ext_area_in ?
                     `BBL_CK_DB_SADDR_EXT : `BBL_CK_DB_SADDR_RAM;
               end
               default: form_ok_out = 1'b0;
            endcase
         end
         // [RULE14] control op timing
         bbl_pkg::OP_SEL: begin
            len_out    = `BBL_LEN_TWO;
            clocks_out = `BBL_CK_SEL;
         end
         bbl_pkg::OP_NOP: ;
         // [RULE11] enable timing
         bbl_pkg::OP_EI,
         // [RULE12] disable timing
         bbl_pkg::OP_DI,
         bbl_pkg::OP_HALT,
         bbl_pkg::OP_STOP: begin
            len_out    = `BBL_LEN_TWO;
            clocks_out = `BBL_CK_CTRL;
         end
         default: form_ok_out = 1'b0;
      endcase
   end

endmodule : bbl_timing
`default_nettype wire
